/* pkg/mefb_pkg.sv */
// Package with register map, field positions and reset values of the metering event flag bank
package mefb_pkg;
	// Register byte offsets on the APB
	localparam logic [7:0] OFS_FLAGS_FIRST = 8'h00;
	localparam logic [7:0] OFS_FLAGS_SECOND = 8'h04;
	localparam logic [7:0] OFS_MASK_FIRST = 8'h08;
	localparam logic [7:0] OFS_MASK_SECOND = 8'h0C;
	localparam logic [7:0] OFS_POWER_SIGN = 8'h10;
	localparam logic [7:0] OFS_NOLOAD_PHASE = 8'h14;
	localparam logic [7:0] OFS_PULSE_CONFIG = 8'h18;

	// First event flag word bit positions
	localparam int BIT_SUM2_SIGN_CHANGE = 13;
	localparam int BIT_PULSE1_FALL = 14;
	localparam int BIT_PULSE2_FALL = 15;
	localparam int BIT_PULSE3_FALL = 16;
	localparam int BIT_COMPUTE_DONE = 17;
	localparam int BIT_SUM3_SIGN_CHANGE = 18;
	localparam logic [31:0] FIRST_IMPL_MASK = 32'h0007E000;

	// Second event flag word bit positions
	localparam int BIT_TOTAL_NOLOAD = 0;
	localparam int BIT_FUND_NOLOAD = 1;
	localparam int BIT_APPARENT_NOLOAD = 2;
	localparam int BIT_VOLT_TIMEOUT_A = 3;
	localparam int BIT_CURR_TIMEOUT_A = 6;
	localparam int BIT_VOLT_SEEN_A = 9;
	localparam logic [31:0] SECOND_IMPL_MASK = 32'h00000FFF;

	// Power sign register fields
	localparam int BIT_PATH2_SUM_SIGN = 7;
	localparam int BIT_PATH3_SUM_SIGN = 8;

	// No-load phase register fields (low bit of each 3-bit group)
	localparam int POS_TOTAL_PHASES = 0;
	localparam int POS_FUND_PHASES = 3;
	localparam int POS_APPARENT_PHASES = 6;

	// Pulse output configuration fields
	localparam int POS_PULSE1_SOURCE = 0;
	localparam int POS_PULSE2_SOURCE = 3;
	localparam int POS_PULSE3_SOURCE = 6;
	localparam int BIT_PULSE1_DISABLE = 9;
	localparam int BIT_PULSE2_DISABLE = 10;
	localparam int BIT_PULSE3_DISABLE = 11;
	localparam logic [15:0] PULSE_CONFIG_WMASK = 16'h0FFF;

	// Reset values
	localparam logic [31:0] FLAGS_RESET = 32'h00000000;
	localparam logic [31:0] MASK_RESET = 32'h00000000;
	localparam logic [15:0] PULSE_CONFIG_RESET = 16'h0000;
	localparam logic [31:0] BUS_READ_IDLE = 32'h00000000;

	typedef enum {
		MEFB_REG_FLAGS_FIRST,
		MEFB_REG_FLAGS_SECOND,
		MEFB_REG_MASK_FIRST,
		MEFB_REG_MASK_SECOND,
		MEFB_REG_POWER_SIGN,
		MEFB_REG_NOLOAD_PHASE,
		MEFB_REG_PULSE_CONFIG,
		MEFB_REG_NONE
	} mefb_reg_sel_t;
endpackage

/* verilog/mefb_sticky_word.sv */
// Word of sticky event flags, set by hardware and cleared by writing ones
`timescale 1ns/1ps
module mefb_sticky_word #(
	parameter logic [31:0] IMPL_MASK = 32'hFFFFFFFF
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [31:0] setBits,
	input wire logic clearStrobe,
	input wire logic [31:0] clearBits,
	output logic [31:0] flags
);
	import mefb_pkg::*;

	logic [31:0] next_flags;

	always_comb begin
		next_flags = flags;
		if (clearStrobe) begin
			next_flags = next_flags & ~clearBits;
		end
		// A set in the clearing cycle wins, so no event is dropped
		next_flags = (next_flags | setBits) & IMPL_MASK;
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			flags <= FLAGS_RESET;
		end else begin
			flags <= next_flags;
		end
	end
endmodule

/* verilog/mefb_flag_bank.sv */
// Metering event flag bank: event capture, pulse output gating, APB register file and interrupt
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps
module mefb_flag_bank (
	input wire logic core_clk,
	input wire logic reset,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pulse generators, same clock; idle high, active low pulses
	input wire logic pulseGen1,
	input wire logic pulseGen2,
	input wire logic pulseGen3,
	output logic [2:0] pulse_out_1_source,
	output logic [2:0] pulse_out_2_source,
	output logic [2:0] pulse_out_3_source,
	output logic pulse_out_1,
	output logic pulse_out_2,
	output logic pulse_out_3,
	// Summed power signs of pulse paths 2 and 3, 1 means negative
	input wire logic path2_sum_sign,
	input wire logic path3_sum_sign,
	// One-cycle strobe at the end of each computation pass
	input wire logic compute_pass_done,
	// No-load phase levels, bit 0 phase A
	input wire logic [2:0] total_noload_phases,
	input wire logic [2:0] fundamental_noload_phases,
	input wire logic [2:0] apparent_noload_phases,
	// One-cycle detector strobes, bit 0 phase A
	input wire logic [2:0] voltCrossingTimeout,
	input wire logic [2:0] currCrossingTimeout,
	input wire logic [2:0] voltCrossingSeen,
	output logic irq
);
	import mefb_pkg::*;

	function automatic mefb_reg_sel_t decode_addr(input logic [7:0] addr);
		case (addr)
			OFS_FLAGS_FIRST: decode_addr = MEFB_REG_FLAGS_FIRST;
			OFS_FLAGS_SECOND: decode_addr = MEFB_REG_FLAGS_SECOND;
			OFS_MASK_FIRST: decode_addr = MEFB_REG_MASK_FIRST;
			OFS_MASK_SECOND: decode_addr = MEFB_REG_MASK_SECOND;
			OFS_POWER_SIGN: decode_addr = MEFB_REG_POWER_SIGN;
			OFS_NOLOAD_PHASE: decode_addr = MEFB_REG_NOLOAD_PHASE;
			OFS_PULSE_CONFIG: decode_addr = MEFB_REG_PULSE_CONFIG;
			default: decode_addr = MEFB_REG_NONE;
		endcase
	endfunction

	// Rising edge of any bit of a phase vector: a phase has just entered no-load
	function automatic logic any_entry(input logic [2:0] cur, input logic [2:0] prev);
		any_entry = |(cur & ~prev);
	endfunction

	// Bus decode
	mefb_reg_sel_t regSel;
	logic accessPhase;
	logic setupPhase;
	logic busWrite;

	// Software state
	logic [31:0] maskFirst;
	logic [31:0] maskSecond;
	logic [15:0] pulseConfig;
	logic [31:0] next_maskFirst;
	logic [31:0] next_maskSecond;
	logic [15:0] next_pulseConfig;
	logic [31:0] next_prdata;

	// Event history
	logic path2Sign;
	logic path3Sign;
	logic pulsePrev1;
	logic pulsePrev2;
	logic pulsePrev3;
	logic [2:0] totalPrev;
	logic [2:0] fundPrev;
	logic [2:0] apparentPrev;
	logic next_path2Sign;
	logic next_path3Sign;
	logic next_pulsePrev1;
	logic next_pulsePrev2;
	logic next_pulsePrev3;
	logic [2:0] next_totalPrev;
	logic [2:0] next_fundPrev;
	logic [2:0] next_apparentPrev;
	logic [2:0] noloadTotal;
	logic [2:0] noloadFund;
	logic [2:0] noloadApparent;
	logic [2:0] next_noloadTotal;
	logic [2:0] next_noloadFund;
	logic [2:0] next_noloadApparent;

	// Pulse pins
	logic next_pulse_out_1;
	logic next_pulse_out_2;
	logic next_pulse_out_3;

	// Flag words
	logic [31:0] setFirst;
	logic [31:0] setSecond;
	logic [31:0] power_event_flags_first;
	logic [31:0] load_crossing_flags_second;
	logic clearFirst;
	logic clearSecond;
	logic [15:0] power_sign_register;
	logic [15:0] noload_phase_register;

	// Unmasked pending events per word
	logic pendingFirst;
	logic pendingSecond;

	assign regSel = decode_addr(paddr);
	assign setupPhase = psel & ~penable;
	assign accessPhase = psel & penable;
	// Zero wait states: every access completes in its first access cycle
	assign pready = accessPhase;
	// Writes to the read-only views are dropped without an error
	assign pslverr = accessPhase & (regSel == MEFB_REG_NONE);
	assign busWrite = accessPhase & pwrite;

	assign clearFirst = busWrite & (regSel == MEFB_REG_FLAGS_FIRST);
	assign clearSecond = busWrite & (regSel == MEFB_REG_FLAGS_SECOND);

	// Register views
	always_comb begin
		power_sign_register = 16'h0000;
		power_sign_register[BIT_PATH2_SUM_SIGN] = path2Sign;
		power_sign_register[BIT_PATH3_SUM_SIGN] = path3Sign;
		noload_phase_register = 16'h0000;
		noload_phase_register[POS_TOTAL_PHASES +: 3] = noloadTotal;
		noload_phase_register[POS_FUND_PHASES +: 3] = noloadFund;
		noload_phase_register[POS_APPARENT_PHASES +: 3] = noloadApparent;
	end

	assign pulse_out_1_source = pulseConfig[POS_PULSE1_SOURCE +: 3];
	assign pulse_out_2_source = pulseConfig[POS_PULSE2_SOURCE +: 3];
	assign pulse_out_3_source = pulseConfig[POS_PULSE3_SOURCE +: 3];

	// Event detection
	always_comb begin
		next_path2Sign = path2_sum_sign;
		next_path3Sign = path3_sum_sign;
		next_pulsePrev1 = pulseGen1;
		next_pulsePrev2 = pulseGen2;
		next_pulsePrev3 = pulseGen3;
		next_totalPrev = total_noload_phases;
		next_fundPrev = fundamental_noload_phases;
		next_apparentPrev = apparent_noload_phases;
		next_noloadTotal = total_noload_phases;
		next_noloadFund = fundamental_noload_phases;
		next_noloadApparent = apparent_noload_phases;

		setFirst = 32'h00000000;
		setFirst[BIT_SUM2_SIGN_CHANGE] = path2_sum_sign ^ path2Sign;
		// Edges are taken from the generator, ahead of the disable gate
		setFirst[BIT_PULSE1_FALL] = pulsePrev1 & ~pulseGen1;
		setFirst[BIT_PULSE2_FALL] = pulsePrev2 & ~pulseGen2;
		setFirst[BIT_PULSE3_FALL] = pulsePrev3 & ~pulseGen3;
		setFirst[BIT_COMPUTE_DONE] = compute_pass_done;
		setFirst[BIT_SUM3_SIGN_CHANGE] = path3_sum_sign ^ path3Sign;

		setSecond = 32'h00000000;
		setSecond[BIT_TOTAL_NOLOAD] = any_entry(total_noload_phases, totalPrev);
		setSecond[BIT_FUND_NOLOAD] = any_entry(fundamental_noload_phases, fundPrev);
		setSecond[BIT_APPARENT_NOLOAD] = any_entry(apparent_noload_phases, apparentPrev);
		setSecond[BIT_VOLT_TIMEOUT_A +: 3] = voltCrossingTimeout;
		setSecond[BIT_CURR_TIMEOUT_A +: 3] = currCrossingTimeout;
		setSecond[BIT_VOLT_SEEN_A +: 2] = voltCrossingSeen[1:0];
		setSecond[BIT_VOLT_SEEN_A + 2] = voltCrossingSeen[2];
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			// Sign history starts positive: a negative sign at release sets its change flag once
			path2Sign <= 1'b0;
			path3Sign <= 1'b0;
			// Pulse history starts at the idle level, so leaving reset shows no false fall
			pulsePrev1 <= 1'b1;
			pulsePrev2 <= 1'b1;
			pulsePrev3 <= 1'b1;
			totalPrev <= 3'h0;
			fundPrev <= 3'h0;
			apparentPrev <= 3'h0;
			noloadTotal <= 3'h0;
			noloadFund <= 3'h0;
			noloadApparent <= 3'h0;
		end else begin
			path2Sign <= next_path2Sign;
			path3Sign <= next_path3Sign;
			pulsePrev1 <= next_pulsePrev1;
			pulsePrev2 <= next_pulsePrev2;
			pulsePrev3 <= next_pulsePrev3;
			totalPrev <= next_totalPrev;
			fundPrev <= next_fundPrev;
			apparentPrev <= next_apparentPrev;
			noloadTotal <= next_noloadTotal;
			noloadFund <= next_noloadFund;
			noloadApparent <= next_noloadApparent;
		end
	end

	// Sticky flag words; unimplemented bits, 31-19 of the first among them, stay zero
	mefb_sticky_word #(
		.IMPL_MASK(FIRST_IMPL_MASK)
	) u_flags_first (
		.core_clk(core_clk),
		.reset(reset),
		.setBits(setFirst),
		.clearStrobe(clearFirst),
		.clearBits(pwdata),
		.flags(power_event_flags_first)
	);

	mefb_sticky_word #(
		.IMPL_MASK(SECOND_IMPL_MASK)
	) u_flags_second (
		.core_clk(core_clk),
		.reset(reset),
		.setBits(setSecond),
		.clearStrobe(clearSecond),
		.clearBits(pwdata),
		.flags(load_crossing_flags_second)
	);

	// Pulse pins: a disabled output idles high, a registered copy otherwise
	always_comb begin
		next_pulse_out_1 = pulseGen1 | pulseConfig[BIT_PULSE1_DISABLE];
		next_pulse_out_2 = pulseGen2 | pulseConfig[BIT_PULSE2_DISABLE];
		next_pulse_out_3 = pulseGen3 | pulseConfig[BIT_PULSE3_DISABLE];
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			pulse_out_1 <= 1'b1;
			pulse_out_2 <= 1'b1;
			pulse_out_3 <= 1'b1;
		end else begin
			pulse_out_1 <= next_pulse_out_1;
			pulse_out_2 <= next_pulse_out_2;
			pulse_out_3 <= next_pulse_out_3;
		end
	end

	// Software writable registers; flag words take only write-one-to-clear
	always_comb begin
		next_maskFirst = maskFirst;
		next_maskSecond = maskSecond;
		next_pulseConfig = pulseConfig;
		if (busWrite) begin
			case (regSel)
				MEFB_REG_MASK_FIRST: begin
					next_maskFirst = pwdata & FIRST_IMPL_MASK;
				end
				MEFB_REG_MASK_SECOND: begin
					next_maskSecond = pwdata & SECOND_IMPL_MASK;
				end
				MEFB_REG_PULSE_CONFIG: begin
					next_pulseConfig = pwdata[15:0] & PULSE_CONFIG_WMASK;
				end
				default: begin
					next_pulseConfig = pulseConfig;
				end
			endcase
		end
	end

	// Read data is captured in the setup cycle so it comes from a flip-flop
	always_comb begin
		next_prdata = prdata;
		if (setupPhase) begin
			case (regSel)
				MEFB_REG_FLAGS_FIRST: begin
					next_prdata = power_event_flags_first;
				end
				MEFB_REG_FLAGS_SECOND: begin
					next_prdata = load_crossing_flags_second;
				end
				MEFB_REG_MASK_FIRST: begin
					next_prdata = maskFirst;
				end
				MEFB_REG_MASK_SECOND: begin
					next_prdata = maskSecond;
				end
				MEFB_REG_POWER_SIGN: begin
					next_prdata = {16'h0000, power_sign_register};
				end
				MEFB_REG_NOLOAD_PHASE: begin
					next_prdata = {16'h0000, noload_phase_register};
				end
				MEFB_REG_PULSE_CONFIG: begin
					next_prdata = {16'h0000, pulseConfig};
				end
				default: begin
					next_prdata = BUS_READ_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			maskFirst <= MASK_RESET;
			maskSecond <= MASK_RESET;
			pulseConfig <= PULSE_CONFIG_RESET;
			prdata <= BUS_READ_IDLE;
		end else begin
			maskFirst <= next_maskFirst;
			maskSecond <= next_maskSecond;
			pulseConfig <= next_pulseConfig;
			prdata <= next_prdata;
		end
	end

	// Level interrupt, high while any unmasked flag stands
	assign pendingFirst = |(power_event_flags_first & maskFirst);
	assign pendingSecond = |(load_crossing_flags_second & maskSecond);
	// A read captures flags in the setup cycle, so a flag set there shows on the next read only
	assign irq = pendingFirst | pendingSecond;
endmodule

/* tb/mefb_flag_bank_monitor.sv */
// Port-level concurrent checks for the metering event flag bank
`timescale 1ns/1ps
module mefb_flag_bank_monitor (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic pulseGen1,
	input wire logic pulseGen3,
	input wire logic pulse_out_1,
	input wire logic pulse_out_3,
	input wire logic [2:0] pulse_out_1_source,
	input wire logic [2:0] pulse_out_2_source,
	input wire logic [2:0] pulse_out_3_source,
	input wire logic path2_sum_sign,
	input wire logic path3_sum_sign,
	input wire logic irq
);
	import mefb_pkg::*;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	logic acc;
	logic cfgWr;
	logic [8:0] src;
	assign acc = psel && penable;
	assign cfgWr = acc && pwrite && paddr == OFS_PULSE_CONFIG;
	assign src = {pulse_out_3_source, pulse_out_2_source, pulse_out_1_source};
	ready_zero_wait_a: assert property (pready == acc)
		else $error("pready differs from access phase");
	unmapped_error_a: assert property (acc && paddr >= 8'h1C |-> pslverr)
		else $error("no error on unmapped access");
	source_load_a: assert property (cfgWr |=> src == $past(pwdata[8:0]))
		else $error("source fields not loaded");
	// Sources may only move on a config write
	source_hold_a: assert property (!cfgWr |=> $stable(src))
		else $error("source fields moved without write");
	first_upper_zero_a: assert property (acc && !pwrite && paddr == OFS_FLAGS_FIRST |-> prdata[31:19] == 13'h0)
		else $error("upper first word bits not zero");
	irq_sticky_a: assert property (irq && !(acc && pwrite) |=> irq)
		else $error("irq dropped without a write");
	sign_readback_a: assert property (acc && !pwrite && paddr == OFS_POWER_SIGN
		|-> prdata[8:7] == $past({path3_sum_sign, path2_sum_sign}, 2))
		else $error("power sign readback wrong");
	pulse_idle_high_a: assert property (pulseGen1 |=> pulse_out_1)
		else $error("pulse pin low while generator idle");
	pulse_low_cause_a: assert property ($fell(pulse_out_3) |-> !$past(pulseGen3))
		else $error("pulse pin fell without generator pulse");
endmodule

bind mefb_flag_bank mefb_flag_bank_monitor i_mefb_flag_bank_monitor (.core_clk(core_clk), .reset(reset),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .pulseGen1(pulseGen1), .pulseGen3(pulseGen3),
	.pulse_out_1(pulse_out_1), .pulse_out_3(pulse_out_3), .pulse_out_1_source(pulse_out_1_source),
	.pulse_out_2_source(pulse_out_2_source), .pulse_out_3_source(pulse_out_3_source),
	.path2_sum_sign(path2_sum_sign), .path3_sum_sign(path3_sum_sign), .irq(irq));

/* tb/mefb_flag_bank_tb.sv */
// Self-checking testbench for the metering event flag bank
`timescale 1ns/1ps
module mefb_flag_bank_tb;
	import mefb_pkg::*;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, irq, er, po1, po2, po3;
	logic [2:0] gen = 3'h7, src1, src2, src3;
	logic s2 = 1'b0, s3 = 1'b0, done = 1'b0;
	logic [8:0] nlv = 9'h0, stb = 9'h0;
	int failCount = 0, nCompared = 0;
	always #25 core_clk = ~core_clk;
	mefb_flag_bank i_mefb_flag_bank (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pulseGen1(gen[0]), .pulseGen2(gen[1]), .pulseGen3(gen[2]), .pulse_out_1_source(src1),
		.pulse_out_2_source(src2), .pulse_out_3_source(src3), .pulse_out_1(po1), .pulse_out_2(po2),
		.pulse_out_3(po3), .path2_sum_sign(s2), .path3_sum_sign(s3), .compute_pass_done(done),
		.total_noload_phases(nlv[2:0]), .fundamental_noload_phases(nlv[5:3]), .apparent_noload_phases(nlv[8:6]),
		.voltCrossingTimeout(stb[2:0]), .currCrossingTimeout(stb[5:3]), .voltCrossingSeen(stb[8:6]), .irq(irq));
	task automatic report_and_stop();
		if (failCount == 0 && nCompared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		nCompared++;
		if (seen !== exp) begin
			failCount++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Entered just after a rising edge; leaves one idle cycle so psel is never driven twice at once
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		check(nm, rd, exp);
	endtask
	task automatic fire1(input int j);
		case (j)
			0: s2 <= ~s2;
			1, 2, 3: gen[j - 1] <= 1'b0;
			4: done <= 1'b1;
			default: s3 <= ~s3;
		endcase
		@(posedge core_clk);
		gen <= 3'h7;
		done <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic fire2(input int i);
		if (i < 3) nlv[4 * i] <= 1'b1;
		else stb[i - 3] <= 1'b1;
		@(posedge core_clk);
		stb <= 9'h0;
		@(posedge core_clk);
	endtask
	// Generator held two cycles so the registered pin is settled when sampled
	task automatic pins(input logic [2:0] g, input logic [31:0] exp);
		gen <= g;
		repeat (2) @(posedge core_clk);
		check("pulse pins", {29'h0, po3, po2, po1}, exp);
		gen <= 3'h7;
		@(posedge core_clk);
	endtask
	task automatic irqchk(input string nm, input logic exp);
		check(nm, {31'h0, irq}, {31'h0, exp});
	endtask
	initial begin
		repeat (3000) @(posedge core_clk);
		failCount++;
		report_and_stop();
	end
	initial begin
		repeat (5) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		for (int k = 0; k < 7; k++) rdchk("reset value", 8'(4 * k), 32'h0);
		xfer(1'b1, 8'h1C, 32'hFFFFFFFF);
		xfer(1'b0, 8'h1C, 32'h0);
		check("unmapped error", {31'h0, er}, 32'h1);
		check("unmapped data", rd, 32'h0);
		for (int j = 0; j < 6; j++) begin
			fire1(j);
			rdchk("first word", OFS_FLAGS_FIRST, 32'h1 << (13 + j));
			rdchk("first word kept", OFS_FLAGS_FIRST, 32'h1 << (13 + j));
			xfer(1'b1, OFS_FLAGS_FIRST, 32'h1 << (13 + j));
			rdchk("first word cleared", OFS_FLAGS_FIRST, 32'h0);
		end
		rdchk("power sign", OFS_POWER_SIGN, 32'h180);
		for (int i = 0; i < 12; i++) begin
			fire2(i);
			rdchk("second word", OFS_FLAGS_SECOND, 32'h1 << i);
			xfer(1'b1, OFS_FLAGS_SECOND, 32'h1 << i);
		end
		rdchk("noload phases", OFS_NOLOAD_PHASE, 32'h111);
		rdchk("second word cleared", OFS_FLAGS_SECOND, 32'h0);
		xfer(1'b1, OFS_PULSE_CONFIG, 32'hFFFFFED1);
		rdchk("config", OFS_PULSE_CONFIG, 32'hED1);
		check("sources", {23'h0, src3, src2, src1}, 32'hD1);
		pins(3'h0, 32'h7);
		rdchk("falls while disabled", OFS_FLAGS_FIRST, 32'h1C000);
		xfer(1'b1, OFS_PULSE_CONFIG, 32'h0);
		pins(3'h6, 32'h6);
		pins(3'h5, 32'h5);
		pins(3'h3, 32'h3);
		xfer(1'b1, OFS_FLAGS_FIRST, 32'hFFFFFFFF);
		irqchk("irq idle", 1'b0);
		xfer(1'b1, OFS_MASK_FIRST, 32'h1 << BIT_COMPUTE_DONE);
		fire1(4);
		irqchk("irq raised", 1'b1);
		xfer(1'b1, OFS_MASK_FIRST, 32'h0);
		irqchk("irq masked", 1'b0);
		xfer(1'b1, OFS_MASK_FIRST, 32'h20000);
		irqchk("irq unmasked", 1'b1);
		xfer(1'b1, OFS_FLAGS_FIRST, 32'h20000);
		irqchk("irq cleared", 1'b0);
		xfer(1'b1, OFS_MASK_SECOND, 32'h800);
		fire2(11);
		irqchk("irq second word", 1'b1);
		xfer(1'b1, OFS_FLAGS_SECOND, 32'h800);
		irqchk("irq second cleared", 1'b0);
		report_and_stop();
	end
endmodule
